/* File: lvs_takeover.sv */
/*
 * Steering takeover block: automatic and manual steering commands to the
 * launch vehicle autopilot via the error counters, restart sequencing,
 * coarse-align bypass and engine-off output, with an AHB-Lite slave.
 * Assumes a single hclk domain; panel and hand controller pins are async.
 */
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps

module lvs_takeover #(
   parameter int unsigned TICK_CYCLES = lvs_pkg::CYCLE_CLKS
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Panel switch and hand controller pins
   input wire logic vehicle_guidance_switch,
   input wire lvs_pkg::lvs_hc_s rotational_hand_controller,
   // Autopilot side
   output lvs_pkg::lvs_ax3_s error_counter,
   output logic error_counter_load,
   output logic takeover_relay,
   output logic engine_off,
   output logic coarse_align_bypass
);
   import lvs_pkg::*;

   // ==========================================================
   // Parameter check
   // ==========================================================
   if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 2");
   end

   localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
      logic wr_pend;
      logic wr_map;
      logic [7:0] wr_addr;
      logic ascent;
      logic upper;
      logic nav;
      logic [2:0] cfg;
      logic [7:0] scale;
      logic [15:0] poly0;
      logic [15:0] poly1;
      logic [15:0] poly2;
      lvs_ax3_s meas;
      logic [15:0] mgimbal;
      lvs_ax3_s rate;
      logic sw_s1;
      logic sw_s2;
      lvs_hc_s hc_s1;
      lvs_hc_s hc_s2;
      logic manual;
      logic auto_q;
      lvs_ax3_s bias;
      logic [15:0] t;
      logic [31:0] tick_cnt;
      logic tick;
      lvs_rs_e rs;
      logic relay;
      lvs_ax3_s ecnt;
      logic ec_load;
      logic engine_off;
      logic bypass;
   } lvs_state_s;

   lvs_state_s s_r;
   lvs_state_s s_nxt;

   // ==========================================================
   // Functions
   // ==========================================================
   // Saturate a wide signed value into 16 bits
   function automatic logic [15:0] sat16(input logic signed [24:0] v);
      if (v > 25'sd32767) begin
         return 16'h7FFF;
      end else if (v < -25'sd32768) begin
         return 16'h8000;
      end else begin
         return v[15:0];
      end
   endfunction : sat16

   // Scaled automatic command for one axis
   function automatic logic [15:0] steer(input logic [15:0] err, input logic [15:0] bias,
                                         input logic [7:0] sf);
      logic [15:0] d;
      logic signed [24:0] prod;
      d = err - bias;
      prod = $signed(d) * $signed({1'b0, sf});
      return sat16(prod >>> SCALE_FRAC);
   endfunction : steer

   // Manual rate for one axis, sign opposite to the stick
   function automatic logic [15:0] stick(input logic pos, input logic neg,
                                         input logic [15:0] rate);
      if (pos && !neg) begin
         return 16'h0000 - rate;
      end else if (neg && !pos) begin
         return rate;
      end else begin
         return 16'h0000;
      end
   endfunction : stick

   // Magnitude of a signed angle
   function automatic logic [15:0] mag16(input logic [15:0] a);
      return a[15] ? 16'h0000 - a : a;
   endfunction : mag16

   // ==========================================================
   // Next-state logic
   // ==========================================================
   logic auto_act;
   logic cmd_exec;
   logic cmd_eoff;
   logic cmd_prog;
   logic cmd_restart;
   logic [31:0] rdv;
   logic [7:0] rd_addr;
   logic [15:0] pitch_des;
   logic signed [32:0] p1;
   logic [31:0] tt;
   logic signed [48:0] p2;
   logic signed [49:0] psum;
   lvs_ax3_s err;

   always_comb begin
      auto_act = 1'b0;
      cmd_exec = 1'b0;
      cmd_eoff = 1'b0;
      cmd_prog = 1'b0;
      cmd_restart = 1'b0;
      rdv = 32'h0000_0000;
      rd_addr = haddr[7:0];
      s_nxt = s_r;
      s_nxt.ec_load = 1'b0;
      s_nxt.tick = 1'b0;
      s_nxt.hreadyout = 1'b1;
      s_nxt.hresp = 1'b0;

      // Two-stage synchronisers for panel pins
      s_nxt.sw_s1 = vehicle_guidance_switch;
      s_nxt.sw_s2 = s_r.sw_s1;
      s_nxt.hc_s1 = rotational_hand_controller;
      s_nxt.hc_s2 = s_r.hc_s1;

      // Periodic cycle pulse
      if (s_r.tick_cnt >= TICK_LAST) begin
         s_nxt.tick_cnt = 32'h0000_0000;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.tick_cnt = s_r.tick_cnt + 32'h0000_0001;
      end

      // Data phase of a write
      s_nxt.wr_pend = 1'b0;
      if (s_r.wr_pend && s_r.wr_map) begin
         case (s_r.wr_addr)
            OFS_CTRL: begin
               s_nxt.ascent = hwdata[CTRL_ASCENT];
               s_nxt.upper = hwdata[CTRL_UPPER];
               s_nxt.nav = hwdata[CTRL_NAV];
            end
            OFS_CONFIG: s_nxt.cfg = hwdata[2:0];
            OFS_COMMAND: begin
               cmd_exec = hwdata[CMD_EXEC];
               cmd_eoff = hwdata[CMD_ENG_OFF];
               cmd_prog = hwdata[CMD_PROG_SEL];
               cmd_restart = hwdata[CMD_RESTART];
            end
            OFS_SCALE: begin
               s_nxt.scale = (hwdata[7:0] > SCALE_MAX) ? SCALE_MAX : hwdata[7:0];
            end
            OFS_POLY0: s_nxt.poly0 = hwdata[15:0];
            OFS_POLY1: s_nxt.poly1 = hwdata[15:0];
            OFS_POLY2: s_nxt.poly2 = hwdata[15:0];
            OFS_MEAS_P: s_nxt.meas.p = hwdata[15:0];
            OFS_MEAS_Y: s_nxt.meas.y = hwdata[15:0];
            OFS_MEAS_R: s_nxt.meas.r = hwdata[15:0];
            OFS_MGIMBAL: s_nxt.mgimbal = hwdata[15:0];
            OFS_RATE_P: s_nxt.rate.p = hwdata[15:0];
            OFS_RATE_Y: s_nxt.rate.y = hwdata[15:0];
            OFS_RATE_R: s_nxt.rate.r = hwdata[15:0];
            default: begin
            end
         endcase
      end

      // Address phase: latch writes, answer reads
      if (hsel && hready && htrans[1]) begin
         s_nxt.wr_pend = hwrite;
         s_nxt.wr_map = (haddr[31:8] == 24'h000000);
         s_nxt.wr_addr = haddr[7:0];
         if (!hwrite) begin
            case (rd_addr)
               OFS_CTRL: rdv = {29'h0, s_r.nav, s_r.upper, s_r.ascent};
               OFS_CONFIG: rdv = {29'h0, s_r.cfg};
               OFS_SCALE: rdv = {24'h0, s_r.scale};
               OFS_POLY0: rdv = {16'h0, s_r.poly0};
               OFS_POLY1: rdv = {16'h0, s_r.poly1};
               OFS_POLY2: rdv = {16'h0, s_r.poly2};
               OFS_MEAS_P: rdv = {16'h0, s_r.meas.p};
               OFS_MEAS_Y: rdv = {16'h0, s_r.meas.y};
               OFS_MEAS_R: rdv = {16'h0, s_r.meas.r};
               OFS_MGIMBAL: rdv = {16'h0, s_r.mgimbal};
               OFS_RATE_P: rdv = {16'h0, s_r.rate.p};
               OFS_RATE_Y: rdv = {16'h0, s_r.rate.y};
               OFS_RATE_R: rdv = {16'h0, s_r.rate.r};
               OFS_STATUS: begin
                  rdv = {25'h0, (s_r.rs != RS_IDLE), s_r.sw_s2, s_r.bypass,
                         s_r.engine_off, s_r.relay, s_r.manual, s_r.auto_q};
               end
               OFS_ECNT_PY: rdv = {s_r.ecnt.y, s_r.ecnt.p};
               OFS_ECNT_R: rdv = {16'h0, s_r.ecnt.r};
               default: rdv = 32'h0000_0000;
            endcase
            if (haddr[31:8] != 24'h000000) begin
               rdv = 32'h0000_0000;
            end
            s_nxt.hrdata = rdv;
         end
      end

      // Engine-off output; a set in the same write beats the clear
      if (cmd_prog) begin
         s_nxt.engine_off = 1'b0;
      end
      if (cmd_eoff) begin
         s_nxt.engine_off = 1'b1;
      end

      // Manual enable command
      if (cmd_exec) begin
         if (s_r.cfg == CFG_STICK) begin
            s_nxt.manual = 1'b1;
         end else if (s_r.cfg == CFG_OFF) begin
            s_nxt.manual = 1'b0;
         end
      end

      // Automatic mode qualifies on ascent, switch and no manual
      auto_act = s_r.ascent && s_r.sw_s2 && !s_r.manual;
      s_nxt.auto_q = auto_act;

      // Flight time; frozen in upper stage for attitude hold
      if (!s_r.ascent || cmd_prog) begin
         s_nxt.t = 16'h0000;
      end else if (s_r.tick && !s_r.upper && s_r.t != 16'hFFFF) begin
         s_nxt.t = s_r.t + 16'h0001;
      end

      // Pitch polynomial, desired yaw and roll held at zero
      p1 = $signed(s_r.poly1) * $signed({1'b0, s_r.t});
      tt = s_r.t * s_r.t;
      p2 = $signed(s_r.poly2) * $signed({1'b0, tt});
      psum = 50'($signed(s_r.poly0)) + 50'(p1 >>> POLY1_SHIFT) + 50'(p2 >>> POLY2_SHIFT);
      pitch_des = psum[15:0];

      // Raw attitude error per axis
      err.p = pitch_des - s_r.meas.p;
      err.y = 16'h0000 - s_r.meas.y;
      err.r = 16'h0000 - s_r.meas.r;

      // Bias capture on each entry to automatic takeover
      if (auto_act && !s_r.auto_q) begin
         s_nxt.bias = err;
      end

      // Coarse-align bypass near gimbal lock
      s_nxt.bypass = (mag16(s_r.mgimbal) > GIMBAL_LIM) && (s_r.cfg == CFG_STICK)
                     && s_r.nav;

      // Restart sequence and normal steering
      case (s_r.rs)
         RS_IDLE: begin
            if (cmd_restart && (auto_act || s_r.manual)) begin
               s_nxt.relay = 1'b0;
               s_nxt.rs = RS_CLEAR;
            end else begin
               s_nxt.relay = auto_act || s_r.manual;
               if (s_r.manual && s_r.tick) begin
                  // Manual cycle from sampled stick bits
                  s_nxt.ecnt.p = stick(s_r.hc_s2.p_pos, s_r.hc_s2.p_neg, s_r.rate.p);
                  s_nxt.ecnt.y = stick(s_r.hc_s2.y_pos, s_r.hc_s2.y_neg, s_r.rate.y);
                  s_nxt.ecnt.r = stick(s_r.hc_s2.r_pos, s_r.hc_s2.r_neg, s_r.rate.r);
                  s_nxt.ec_load = 1'b1;
               end else if (auto_act && s_r.auto_q && s_r.tick) begin
                  // Automatic steering cycle
                  s_nxt.ecnt.p = steer(err.p, s_r.bias.p, s_r.scale);
                  s_nxt.ecnt.y = steer(err.y, s_r.bias.y, s_r.scale);
                  s_nxt.ecnt.r = steer(err.r, s_r.bias.r, s_r.scale);
                  s_nxt.ec_load = 1'b1;
               end else if (!auto_act && !s_r.manual && s_r.relay) begin
                  // Leaving the loop drops the commands
                  s_nxt.ecnt = '0;
                  s_nxt.ec_load = 1'b1;
               end
            end
         end
         RS_CLEAR: begin
            s_nxt.ecnt = '0;
            s_nxt.ec_load = 1'b1;
            if (auto_act) begin
               s_nxt.bias = err;
            end
            s_nxt.rs = RS_RELAY_ON;
         end
         RS_RELAY_ON: begin
            s_nxt.relay = auto_act || s_r.manual;
            s_nxt.rs = RS_IDLE;
         end
         default: begin
            s_nxt.rs = RS_IDLE;
         end
      endcase
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '0;
         s_r.hreadyout <= 1'b1;
         s_r.scale <= SCALE_RST;
         s_r.rate <= {RATE_RST, RATE_RST, RATE_RST};
         s_r.rs <= RS_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign hreadyout = s_r.hreadyout;
   assign hresp = s_r.hresp;
   assign hrdata = s_r.hrdata;
   assign error_counter = s_r.ecnt;
   assign error_counter_load = s_r.ec_load;
   assign takeover_relay = s_r.relay;
   assign engine_off = s_r.engine_off;
   assign coarse_align_bypass = s_r.bypass;

endmodule : lvs_takeover

/* File: lvs_pkg.sv */
/*
 * Package for the launch vehicle steering takeover block: register map,
 * field positions, reset values, timing constants and carrier types.
 * Assumes a 20 MHz hclk and a 32-bit AHB-Lite register bus.
 */
package lvs_pkg;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned CYCLE_MS = 100;
   localparam int unsigned CYCLE_CLKS = CLK_HZ / 1000 * CYCLE_MS;

   // ==========================================================
   // Register byte offsets
   // ==========================================================
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CONFIG = 8'h04;
   localparam logic [7:0] OFS_COMMAND = 8'h08;
   localparam logic [7:0] OFS_SCALE = 8'h0C;
   localparam logic [7:0] OFS_POLY0 = 8'h10;
   localparam logic [7:0] OFS_POLY1 = 8'h14;
   localparam logic [7:0] OFS_POLY2 = 8'h18;
   localparam logic [7:0] OFS_MEAS_P = 8'h1C;
   localparam logic [7:0] OFS_MEAS_Y = 8'h20;
   localparam logic [7:0] OFS_MEAS_R = 8'h24;
   localparam logic [7:0] OFS_MGIMBAL = 8'h28;
   localparam logic [7:0] OFS_RATE_P = 8'h2C;
   localparam logic [7:0] OFS_RATE_Y = 8'h30;
   localparam logic [7:0] OFS_RATE_R = 8'h34;
   localparam logic [7:0] OFS_STATUS = 8'h38;
   localparam logic [7:0] OFS_ECNT_PY = 8'h3C;
   localparam logic [7:0] OFS_ECNT_R = 8'h40;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int CTRL_ASCENT = 0;
   localparam int CTRL_UPPER = 1;
   localparam int CTRL_NAV = 2;
   localparam int CMD_EXEC = 0;
   localparam int CMD_ENG_OFF = 1;
   localparam int CMD_PROG_SEL = 2;
   localparam int CMD_RESTART = 3;

   // ==========================================================
   // Values
   // ==========================================================
   localparam logic [2:0] CFG_STICK = 3'h3;
   localparam logic [2:0] CFG_OFF = 3'h0;
   localparam int SCALE_FRAC = 4;                  // Scale factor is Q4.4
   localparam logic [7:0] SCALE_MAX = 8'h40;       // 4.0
   localparam logic [7:0] SCALE_RST = 8'h10;       // 1.0
   localparam int POLY1_SHIFT = 8;
   localparam int POLY2_SHIFT = 16;
   // Angle LSB is 360/65536 deg; 85 deg in those units
   localparam logic [15:0] GIMBAL_LIM = 16'h3C71;
   localparam logic [15:0] RATE_RST = 16'h0100;

   // ==========================================================
   // Types
   // ==========================================================
   typedef struct packed {
      logic [15:0] p;
      logic [15:0] y;
      logic [15:0] r;
   } lvs_ax3_s;

   typedef struct packed {
      logic p_pos;
      logic p_neg;
      logic y_pos;
      logic y_neg;
      logic r_pos;
      logic r_neg;
   } lvs_hc_s;

   typedef enum logic [1:0] {
      RS_IDLE = 2'b00,
      RS_CLEAR = 2'b01,
      RS_RELAY_ON = 2'b10
   } lvs_rs_e;

endpackage : lvs_pkg

/* File: lvs_autopilot_model.sv */
/*
 * Autopilot model on the far side of the error counters.
 * Assumes the takeover block's hclk and hresetn.
 */
`timescale 1ns/1ps

module lvs_autopilot_model (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Error counter drive
   input wire lvs_pkg::lvs_ax3_s error_counter,
   input wire logic error_counter_load,
   input wire logic takeover_relay,
   // Command seen by the autopilot
   output lvs_pkg::lvs_ax3_s ap_cmd
);
   import lvs_pkg::*;
   // Latch counters on each load; relay open means no command
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_cmd <= '0;
      end else if (error_counter_load) begin
         ap_cmd <= takeover_relay ? error_counter : '0;
      end
   end
endmodule : lvs_autopilot_model

/* File: lvs_takeover_asserts.sv */
/*
 * Checker for the steering takeover block, bound to its ports.
 * Assumes one hclk domain and a zero-wait slave.
 */
`timescale 1ns/1ps

module lvs_takeover_asserts #(
   parameter int unsigned TICK_CYCLES = 20
) (
   // Clock, reset and bus
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Autopilot side
   input wire lvs_pkg::lvs_ax3_s error_counter,
   input wire logic error_counter_load,
   input wire logic takeover_relay,
   input wire logic engine_off
);
   import lvs_pkg::*;
   localparam int TK = TICK_CYCLES;
   logic cmd_q;
   logic unm_q;
   // ==========================================================
   // Data phase markers
   // ==========================================================
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_q <= 1'b0;
         unm_q <= 1'b0;
      end else if (hready) begin
         cmd_q <= hsel && htrans[1] && hwrite && haddr == {24'h0, OFS_COMMAND};
         unm_q <= hsel && htrans[1] && !hwrite && haddr[31:8] != 24'h0;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_off;
      ##[1:3] !takeover_relay;
   endsequence
   sequence s_zero;
      error_counter == '0 && error_counter_load;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or error");
   a_unmapped_zero: assert property (unm_q |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_count_load: assert property ($changed(error_counter) |-> error_counter_load)
      else $error("counter changed without load");
   a_tick_period: assert property (error_counter_load && takeover_relay
      |-> ##[1:TK] (error_counter_load || !takeover_relay))
      else $error("tick missed");
   a_restart_seq: assert property (cmd_q && hwdata[CMD_RESTART] && takeover_relay
      |-> s_off ##1 s_zero ##1 takeover_relay)
      else $error("restart order broken");
   a_relay_zero: assert property ($fell(takeover_relay) |-> ##[0:1] s_zero)
      else $error("counters not zeroed on relay drop");
   a_engine_set: assert property (cmd_q && hwdata[CMD_ENG_OFF] |-> ##[1:2] engine_off)
      else $error("engine off not set");
   a_engine_clr: assert property (cmd_q && hwdata[CMD_PROG_SEL] && !hwdata[CMD_ENG_OFF]
      |-> ##[1:2] !engine_off)
      else $error("engine off not cleared");
endmodule : lvs_takeover_asserts

bind lvs_takeover lvs_takeover_asserts #(.TICK_CYCLES(TICK_CYCLES)) lvs_takeover_asserts_i (
   .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
   .hresp, .hrdata, .error_counter, .error_counter_load, .takeover_relay, .engine_off
);

/* File: tb_top.sv */
/*
 * Self-checking bench for the steering takeover block.
 * Assumes lvs_pkg, the autopilot model and the bound checker.
 */
`timescale 1ns/1ps

module tb_top;
   import lvs_pkg::*;
   localparam int TK = 20;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, vehicle_guidance_switch;
   logic error_counter_load, takeover_relay, engine_off, coarse_align_bypass;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   lvs_ax3_s error_counter, ap_cmd;
   lvs_hc_s rotational_hand_controller;
   int failures, cmp_count, cyc;
   // ==========================================================
   // Instances
   // ==========================================================
   lvs_takeover #(.TICK_CYCLES(TK)) lvs_takeover_i (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .vehicle_guidance_switch,
      .rotational_hand_controller, .error_counter, .error_counter_load,
      .takeover_relay, .engine_off, .coarse_align_bypass);
   lvs_autopilot_model lvs_autopilot_model_i (.hclk, .hresetn, .error_counter,
      .error_counter_load, .takeover_relay, .ap_cmd);
   // Clock and hang guard
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 12000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [47:0] g, input logic [47:0] e);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // One AHB-Lite single word transfer
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, {24'h0, a}, d);
   endtask : wr
   task automatic wt();
      repeat (2 * TK + 4) @(posedge hclk);
   endtask : wt
   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_regs();
      bus(1'b0, {24'h0, OFS_RATE_P}, 32'h0);
      chk(48'(rd), 48'h100);
      bus(1'b0, 32'h100, 32'h0);
      chk(48'(rd), 48'h0);
      wr(OFS_SCALE, 32'hFF);
      bus(1'b0, {24'h0, OFS_SCALE}, 32'h0);
      chk(48'(rd), 48'h40);
   endtask : t_regs
   task automatic t_auto();
      wr(OFS_MEAS_P, 32'h10);
      wr(OFS_CTRL, 32'h1);
      vehicle_guidance_switch <= 1'b1;
      wt();
      chk(error_counter, 48'h0);
      chk(48'(takeover_relay), 48'h1);
      wr(OFS_MEAS_P, 32'h20);
      wt();
      chk(error_counter, 48'hFFC0_0000_0000);
      vehicle_guidance_switch <= 1'b0;
      repeat (6) @(posedge hclk);
      chk({error_counter[47:1], takeover_relay}, 48'h0);
      vehicle_guidance_switch <= 1'b1;
      wt();
      chk(error_counter, 48'h0);
      wr(OFS_MEAS_P, 32'h30);
      wr(OFS_COMMAND, 32'h8);
      wt();
      chk(error_counter, 48'h0);
      vehicle_guidance_switch <= 1'b0;
   endtask : t_auto
   task automatic t_manual();
      wr(OFS_CONFIG, 32'h3);
      wr(OFS_COMMAND, 32'h1);
      rotational_hand_controller <= lvs_hc_s'(6'b100100);
      wt();
      chk(error_counter, 48'hFF00_0100_0000);
      chk(ap_cmd, 48'hFF00_0100_0000);
      bus(1'b0, {24'h0, OFS_ECNT_PY}, 32'h0);
      chk(48'(rd), 48'h0100_FF00);
      wr(OFS_CTRL, 32'h1);
      vehicle_guidance_switch <= 1'b1;
      wr(OFS_RATE_P, 32'h200);
      rotational_hand_controller <= lvs_hc_s'(6'b100111);
      wt();
      chk(error_counter, 48'hFE00_0100_0000);
      wr(OFS_COMMAND, 32'h8);
      wt();
      chk(ap_cmd, 48'hFE00_0100_0000);
   endtask : t_manual
   task automatic t_bypass();
      wr(OFS_CTRL, 32'h4);
      wr(OFS_MGIMBAL, 32'h3C71);
      repeat (3) @(posedge hclk);
      chk(48'(coarse_align_bypass), 48'h0);
      wr(OFS_MGIMBAL, 32'hC38E);
      repeat (3) @(posedge hclk);
      chk(48'(coarse_align_bypass), 48'h1);
      wr(OFS_CONFIG, 32'h0);
      wr(OFS_COMMAND, 32'h1);
      repeat (4) @(posedge hclk);
      chk({47'h0, coarse_align_bypass | takeover_relay}, 48'h0);
      vehicle_guidance_switch <= 1'b0;
   endtask : t_bypass
   task automatic t_engine();
      wr(OFS_COMMAND, 32'h2);
      repeat (3) @(posedge hclk);
      chk(48'(engine_off), 48'h1);
      bus(1'b0, {24'h0, OFS_STATUS}, 32'h0);
      chk(48'(rd), 48'h8);
      wr(OFS_COMMAND, 32'h4);
      repeat (3) @(posedge hclk);
      chk(48'(engine_off), 48'h0);
      wr(OFS_COMMAND, 32'h6);
      repeat (3) @(posedge hclk);
      chk(48'(engine_off), 48'h1);
   endtask : t_engine
   // Pitch step between two successive counter loads
   task automatic step(output logic [15:0] d);
      logic [15:0] p0;
      do @(posedge hclk); while (error_counter_load !== 1'b1);
      p0 = error_counter.p;
      do @(posedge hclk); while (error_counter_load !== 1'b1);
      d = error_counter.p - p0;
   endtask : step
   // Pitch polynomial in first stage, attitude hold in upper stage
   task automatic t_poly();
      logic [15:0] d;
      wr(OFS_POLY1, 32'h1000);
      wr(OFS_CTRL, 32'h3);
      vehicle_guidance_switch <= 1'b1;
      wt();
      chk(error_counter, 48'h0);
      wr(OFS_POLY0, 32'h10);
      wt();
      chk(error_counter, 48'h0040_0000_0000);
      step(d);
      chk(48'(d), 48'h0);
      wr(OFS_CTRL, 32'h1);
      @(posedge hclk);
      step(d);
      chk(48'(d), 48'h40);
      vehicle_guidance_switch <= 1'b0;
   endtask : t_poly
   // Reset then run every scenario
   initial begin
      {hresetn, hsel, hwrite, vehicle_guidance_switch} = 4'h0;
      htrans = 2'b00;
      haddr = 32'h0;
      hwdata = 32'h0;
      rotational_hand_controller = '0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_auto();
      t_manual();
      t_bypass();
      t_engine();
      t_poly();
      tally_and_finish();
   end
endmodule : tb_top
